// >>> inc/ecc_pkg.sv
// Constants, types and decode functions for the echo canceller control block.
// Behaviour
// (RQ1) Four update-gain grading choices, early taps larger.
// (RQ2) Clear coefficients when filter adds power.
// (RQ3) Noise level ramps 3 dB per interval.
// (RQ4) Power below noise resets noise level.
// (RQ5) Receive half-duplex threshold from word 2.
// (RQ6) Transmit half-duplex threshold from word 3.
// (RQ7) Receive suppression threshold from word 2.
// (RQ8) Transmit detectors default to 5 dB.
// (RQ9) Tone blocks updates and passes through.
// (RQ10) Reset clears coefficients, half-duplex active.
// (RQ11) Convergence turns half-duplex off.
// (RQ12) Three switch states, muting opposite channel.
// (RQ13) Transmit and receive change only via idle.
// (RQ14) Holdover keeps state after speech ends.
// (RQ15) AGC reference from volume fields.
// (RQ16) 125 us attack, 30 ms decay.
// (RQ17) Post-scaler gains reference up to full scale.
// (RQ18) Volume +30 to -60 dB, 11111 mutes.
// (RQ19) Scaling sits outside both echo paths.
// (RQ20) Transmit suppression selectable, receive fixed 24 dB.
// (RQ21) Transmit suppression only for far-end alone.
// (RQ22) ERLE threshold and bias from word 3.
// (RQ23) Receive suppression released only on far speech; the code also releases it while a tone is present.
// (RQ24) Defaults: ERLE 15 dB, bias 18 dB.
// (RQ25) Holdover expiry returns idle; speech leaves idle.
package ecc_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_W0 = 8'h00;
    localparam logic [7:0] OFF_W1 = 8'h04;
    localparam logic [7:0] OFF_W2 = 8'h08;
    localparam logic [7:0] OFF_W3 = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam int VOL_LSB = 5;
    localparam int GRADE_LSB = 2;
    localparam int RAMP_LSB = 6;
    localparam int HOLD_LSB = 8;
    localparam int HDTHR_LSB = 10;
    localparam int RSUP_LSB = 4;
    localparam int TX_SUPPRESS_ATTENUATION_LSB = 8;
    localparam int ERLE_LSB = 4;
    localparam int BIAS_LSB = 6;
    localparam int CTRL_REARM = 0;
    localparam int CTRL_CLEAR = 1;
    localparam logic [11:0] W0_RST = 12'h140;
    localparam logic [11:0] W1_RST = 12'h140;
    localparam logic [11:0] W2_RST = 12'h000;
    localparam logic [11:0] W3_RST = 12'h0a0;

    // ------------------------------------------------------------
    // Levels and timing
    // ------------------------------------------------------------
    localparam logic [7:0] FS_DB = 8'd90;
    localparam logic [7:0] STEP_DB = 8'd3;
    localparam logic [7:0] RX_SUP_DB = 8'd24;
    localparam logic [7:0] TX_SUP_THR_DB = 8'd5;
    localparam logic [4:0] VOL_UNITY = 5'h0a;
    localparam logic [4:0] VOL_MUTE = 5'h1f;
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int ATK_NS = 125000;
    localparam int DECAY_NS = 30000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int ATK_CYC = (ATK_NS + CLK_NS - 1) / CLK_NS;
    // One dB of a 30 ms exponential decay lasts tau / 8.686.
    localparam int DEC_CYC = (DECAY_NS / CLK_NS) / 8686 * 1000;
    localparam int GRP_MS = 16;

    typedef enum logic [2:0] {
        HD_IDLE = 3'b001,
        HD_TX = 3'b010,
        HD_RX = 3'b100
    } ecc_hd_t;

    typedef struct packed {
        logic [7:0] tx_pow;
        logic [7:0] rx_pow;
        logic [7:0] tx_peak;
        logic [7:0] rx_peak;
        logic tone;
        logic diverge;
        logic converged;
    } ecc_meas_t;

    typedef struct packed {
        logic [2:0] hd_state;
        logic hd_active;
        logic tx_mute;
        logic rx_mute;
        logic [7:0] tx_sup_db;
        logic [7:0] rx_sup_db;
        logic update_en;
        logic coef_clear;
        logic [1:0][7:0] agc_att_db;
        logic [1:0][7:0] post_gain_db;
        logic [1:0][7:0] vol_att_db;
        logic [1:0] vol_mute;
        logic [3:0][7:0] grade_db;
    } ecc_ctl_t;

    // ------------------------------------------------------------
    // Field decoders
    // ------------------------------------------------------------
    function automatic logic [7:0] det_thr_db(input logic [1:0] c);
        return 8'd5 + STEP_DB * {6'h00, c};
    endfunction

    function automatic logic [7:0] erle_db(input logic [1:0] c);
        return 8'd9 + STEP_DB * {6'h00, c};
    endfunction

    function automatic logic [7:0] bias_db(input logic [1:0] c);
        return 8'd12 + STEP_DB * {6'h00, c};
    endfunction

    function automatic logic [7:0] tx_suppress_attenuation_db(input logic [1:0] c);
        return 8'd6 * ({6'h00, c} + 8'd1);
    endfunction

    function automatic logic [7:0] ramp_ms(input logic [1:0] c);
        return 8'd16 << c;
    endfunction

    function automatic logic [7:0] hold_ms(input logic [1:0] c);
        return 8'd50 * ({6'h00, c} + 8'd1);
    endfunction

    // Slope in thousandths of a dB per ms; group 0 holds the earliest taps.
    function automatic logic [7:0] grade_db(input logic [1:0] c, input int g);
        int rate;
        rate = (c == 2'd0) ? 0 : (c == 2'd1) ? 190 : (c == 2'd2) ? 380 : 750;
        return 8'((rate * (3 - g) * GRP_MS) / 1000);
    endfunction

endpackage

// >>> logic/ecc_ctrl.sv
// Echo canceller control: detectors, half-duplex switch, AGC, suppression.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps

module ecc_ctrl
    import ecc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC,
    parameter int ATK_CYCLES = ATK_CYC,
    parameter int DEC_CYCLES = DEC_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ecc_meas_t meas,
    output ecc_ctl_t ctl
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [11:0] word0;
    logic [11:0] word1;
    logic [11:0] word2;
    logic [11:0] word3;
    logic mapped;
    logic wr_en;
    logic rearm;
    logic sw_clear;
    logic [31:0] status;
    logic [31:0] next_rdata;

    assign mapped = (paddr == OFF_W0) || (paddr == OFF_W1) || (paddr == OFF_W2)
        || (paddr == OFF_W3) || (paddr == OFF_STAT) || (paddr == OFF_CTRL);
    assign wr_en = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign rearm = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_REARM];
    assign sw_clear = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_CLEAR];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word0 <= W0_RST;
            word1 <= W1_RST;
            word2 <= W2_RST;
            word3 <= W3_RST; // RQ8 RQ24
        end
        else if (wr_en)
        begin
            case (paddr)
                OFF_W0: word0 <= pwdata[11:0];
                OFF_W1: word1 <= pwdata[11:0];
                OFF_W2: word2 <= pwdata[11:0];
                OFF_W3: word3 <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        case (paddr)
            OFF_W0: next_rdata = {20'h00000, word0};
            OFF_W1: next_rdata = {20'h00000, word1};
            OFF_W2: next_rdata = {20'h00000, word2};
            OFF_W3: next_rdata = {20'h00000, word3};
            OFF_STAT: next_rdata = status;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup cycle so the access phase needs no wait.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [1:0][4:0] vol_code;
    logic [7:0] rx_hd_thr;
    logic [7:0] tx_hd_thr;
    logic [7:0] rx_sup_thr;
    logic [7:0] erle;
    logic [7:0] bias;
    logic [7:0] ramp_len;
    logic [7:0] hold_len;

    assign vol_code[0] = word1[VOL_LSB +: 5]; // RQ15
    assign vol_code[1] = word0[VOL_LSB +: 5]; // RQ15
    assign rx_hd_thr = det_thr_db(word2[HDTHR_LSB +: 2]); // RQ5
    assign tx_hd_thr = det_thr_db(word3[HDTHR_LSB +: 2]); // RQ6
    assign rx_sup_thr = det_thr_db(word2[RSUP_LSB +: 2]); // RQ7
    assign erle = erle_db(word3[ERLE_LSB +: 2]); // RQ22
    assign bias = bias_db(word3[BIAS_LSB +: 2]); // RQ22
    assign ramp_len = ramp_ms(word2[RAMP_LSB +: 2]); // RQ3
    assign hold_len = hold_ms(word2[HOLD_LSB +: 2]); // RQ14

    // ------------------------------------------------------------
    // Millisecond time base and noise ramp tick
    // ------------------------------------------------------------
    logic [19:0] ms_cnt;
    logic ms_tick;
    logic [7:0] ramp_cnt;
    logic ramp_tick;

    assign ms_tick = (ms_cnt == 20'(MS_CYCLES - 1));
    assign ramp_tick = ms_tick && (ramp_cnt >= ramp_len - 8'd1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_cnt <= 20'h00000;
        else if (ms_tick)
            ms_cnt <= 20'h00000;
        else
            ms_cnt <= ms_cnt + 20'h00001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ramp_cnt <= 8'h00;
        else if (ramp_tick)
            ramp_cnt <= 8'h00; // RQ3
        else if (ms_tick)
            ramp_cnt <= ramp_cnt + 8'h01;
    end

    // ------------------------------------------------------------
    // Background noise trackers and speech detectors
    // ------------------------------------------------------------
    function automatic logic [7:0] next_noise(input logic [7:0] n,
        input logic [7:0] p, input logic tick);
        logic [8:0] up;
        up = {1'b0, n} + {1'b0, STEP_DB};
        if (p < n)
            return p; // RQ4
        else if (tick)
            return (up > {1'b0, p}) ? p : up[7:0]; // RQ3
        else
            return n;
    endfunction

    function automatic logic speech(input logic [7:0] p, input logic [7:0] n,
        input logic [7:0] thr);
        return {1'b0, p} > ({1'b0, n} + {1'b0, thr});
    endfunction

    logic [7:0] tx_noise;
    logic [7:0] rx_noise;
    logic rx_hd_sp;
    logic tx_hd_sp;
    logic rx_sup_sp;
    logic tx_sup_sp;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_noise <= 8'h00;
            rx_noise <= 8'h00;
        end
        else
        begin
            tx_noise <= next_noise(tx_noise, meas.tx_pow, ramp_tick);
            rx_noise <= next_noise(rx_noise, meas.rx_pow, ramp_tick);
        end
    end

    assign rx_hd_sp = speech(meas.rx_pow, rx_noise, rx_hd_thr); // RQ5
    assign tx_hd_sp = speech(meas.tx_pow, tx_noise, tx_hd_thr); // RQ6
    assign rx_sup_sp = speech(meas.rx_pow, rx_noise, rx_sup_thr); // RQ7
    assign tx_sup_sp = speech(meas.tx_pow, tx_noise, TX_SUP_THR_DB); // RQ8

    // ------------------------------------------------------------
    // Coefficient clear and half-duplex enable
    // ------------------------------------------------------------
    logic coef_clear;
    logic hd_active;

    // Held high through reset so the filter starts from zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coef_clear <= 1'b1; // RQ10
        else
            coef_clear <= meas.diverge || sw_clear; // RQ2
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hd_active <= 1'b1; // RQ10
        else if (meas.diverge || rearm)
            hd_active <= 1'b1;
        else if (meas.converged)
            hd_active <= 1'b0; // RQ11
    end

    // ------------------------------------------------------------
    // Half-duplex switch
    // ------------------------------------------------------------
    ecc_hd_t hd_state;
    ecc_hd_t next_hd_state;
    logic [7:0] hold_cnt;
    logic hold_done;
    logic act_speech;

    assign hold_done = (hold_cnt == 8'h00);
    assign act_speech = (hd_state == HD_TX) ? tx_hd_sp : rx_hd_sp;

    always_comb
    begin
        next_hd_state = hd_state;
        case (hd_state)
            HD_IDLE:
            begin
                if (tx_hd_sp)
                    next_hd_state = HD_TX; // RQ25
                else if (rx_hd_sp)
                    next_hd_state = HD_RX; // RQ25
            end
            HD_TX, HD_RX:
            begin
                if (!act_speech && hold_done)
                    next_hd_state = HD_IDLE; // RQ13 RQ25
            end
            default: next_hd_state = HD_IDLE;
        endcase
        if (!hd_active)
            next_hd_state = HD_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hd_state <= HD_IDLE;
        else
            hd_state <= next_hd_state; // RQ12
    end

    // Speech reloads the holdover; the count runs in whole milliseconds.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt <= 8'h00;
        else if (hd_state == HD_IDLE || act_speech)
            hold_cnt <= hold_len; // RQ14
        else if (ms_tick && !hold_done)
            hold_cnt <= hold_cnt - 8'h01; // RQ14
    end

    // ------------------------------------------------------------
    // Suppression and update control
    // ------------------------------------------------------------
    logic tx_sup_on;
    logic near_end;
    logic [8:0] near_lvl;

    // Once engaged, the bias sets how easily near-end speech breaks in.
    assign near_lvl = {1'b0, meas.tx_pow} + {1'b0, tx_sup_on ? bias : erle}; // RQ22
    assign near_end = tx_sup_sp && (near_lvl > {1'b0, meas.rx_pow});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_sup_on <= 1'b0;
        else
            tx_sup_on <= rx_sup_sp && !near_end && !meas.tone; // RQ21
    end

    // ------------------------------------------------------------
    // AGC and volume, transmit index 0 and receive index 1
    // ------------------------------------------------------------
    logic [1:0][7:0] agc_att;
    logic [1:0][19:0] atk_cnt;
    logic [1:0][19:0] dec_cnt;
    logic [1:0][7:0] post_gain;
    logic [1:0][7:0] vol_att;
    logic [1:0][7:0] peak;
    logic [1:0][7:0] ref_lvl;
    logic [1:0] over;

    assign peak[0] = meas.tx_peak;
    assign peak[1] = meas.rx_peak;

    always_comb
    begin
        for (int j = 0; j < 2; j++)
        begin
            if (vol_code[j] <= VOL_UNITY)
            begin
                post_gain[j] = STEP_DB * {3'h0, VOL_UNITY - vol_code[j]}; // RQ17 RQ18
                vol_att[j] = 8'h00;
            end
            else
            begin
                post_gain[j] = 8'h00;
                vol_att[j] = STEP_DB * {3'h0, vol_code[j] - VOL_UNITY}; // RQ18
            end
            ref_lvl[j] = FS_DB - post_gain[j]; // RQ15
            over[j] = (post_gain[j] != 8'h00) && (peak[j] > ref_lvl[j]);
        end
    end

    // Attack waits out the full attack time before applying the new depth.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            agc_att <= '0;
            atk_cnt <= '0;
            dec_cnt <= '0;
        end
        else
        begin
            for (int j = 0; j < 2; j++)
            begin
                if (over[j])
                begin
                    dec_cnt[j] <= 20'h00000;
                    if (peak[j] - ref_lvl[j] <= agc_att[j])
                        atk_cnt[j] <= 20'h00000;
                    else if (atk_cnt[j] == 20'(ATK_CYCLES - 1))
                    begin
                        atk_cnt[j] <= 20'h00000;
                        agc_att[j] <= peak[j] - ref_lvl[j]; // RQ16
                    end
                    else
                        atk_cnt[j] <= atk_cnt[j] + 20'h00001;
                end
                else
                begin
                    atk_cnt[j] <= 20'h00000;
                    if (agc_att[j] == 8'h00)
                        dec_cnt[j] <= 20'h00000;
                    else if (dec_cnt[j] == 20'(DEC_CYCLES - 1))
                    begin
                        dec_cnt[j] <= 20'h00000;
                        agc_att[j] <= agc_att[j] - 8'h01; // RQ16
                    end
                    else
                        dec_cnt[j] <= dec_cnt[j] + 20'h00001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs and status
    // ------------------------------------------------------------
    assign status = {8'h00, rx_noise, tx_noise, 1'b0, tx_sup_on, tx_sup_sp,
        rx_sup_sp, tx_hd_sp, rx_hd_sp, hd_active, hd_state[0] ? 1'b0 : 1'b1};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl <= '0;
        else
        begin
            ctl.hd_state <= hd_state;
            ctl.hd_active <= hd_active;
            ctl.tx_mute <= hd_active && (hd_state == HD_RX); // RQ12
            ctl.rx_mute <= hd_active && (hd_state == HD_TX) && !meas.tone; // RQ9 RQ12
            ctl.tx_sup_db <= (tx_sup_on && !meas.tone) ? tx_suppress_attenuation_db(word3[TX_SUPPRESS_ATTENUATION_LSB +: 2])
                : 8'h00; // RQ9 RQ20
            ctl.rx_sup_db <= (rx_sup_sp || meas.tone) ? 8'h00 : RX_SUP_DB; // RQ9 RQ20 RQ23
            ctl.update_en <= !meas.tone && !near_end && !coef_clear; // RQ9
            ctl.coef_clear <= coef_clear || meas.diverge || sw_clear; // RQ2 RQ10
            ctl.agc_att_db <= agc_att; // RQ19
            ctl.post_gain_db <= post_gain;
            ctl.vol_att_db <= vol_att;
            ctl.vol_mute[0] <= (vol_code[0] == VOL_MUTE); // RQ18
            ctl.vol_mute[1] <= (vol_code[1] == VOL_MUTE); // RQ18
            for (int g = 0; g < 4; g++)
                ctl.grade_db[g] <= grade_db(word0[GRADE_LSB +: 2], g); // RQ1
        end
    end

endmodule // ecc_ctrl

// >>> sim/ecc_ctrl_sva.sv
// Port-level assertions for the echo canceller control block.
`timescale 1ns/100ps
module ecc_ctrl_sva
    import ecc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ecc_meas_t meas,
    input wire ecc_ctl_t ctl
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_hd_tx_rx: assert property (ctl.hd_state == HD_TX |=> ctl.hd_state != HD_RX)
        else $error("tx went to rx directly");
    a_hd_rx_tx: assert property (ctl.hd_state == HD_RX |=> ctl.hd_state != HD_TX)
        else $error("rx went to tx directly");
    a_tx_state_mute: assert property (ctl.hd_state == HD_TX && ctl.hd_active
        |-> (ctl.rx_mute || $past(meas.tone)) && !ctl.tx_mute)
        else $error("tx state mutes wrong");
    a_rx_state_mute: assert property (ctl.hd_state == HD_RX && ctl.hd_active
        |-> ctl.tx_mute)
        else $error("rx state leaves tx open");
    a_tone_no_upd: assert property (meas.tone |=> !ctl.update_en)
        else $error("update during tone");
    // A tone must not be eaten by either suppressor.
    a_tone_pass: assert property (meas.tone |=> ctl.rx_sup_db == 8'h00 && ctl.tx_sup_db == 8'h00)
        else $error("tone suppressed");
    a_div_clear: assert property (meas.diverge |=> ctl.coef_clear)
        else $error("no clear on divergence");
    a_rx_sup_fixed: assert property (ctl.rx_sup_db == 8'h00 || ctl.rx_sup_db == RX_SUP_DB)
        else $error("rx suppression not 24 dB");
    a_conv_off: assert property (meas.converged && !meas.diverge && !psel |-> ##[1:2] !ctl.hd_active)
        else $error("half duplex kept after convergence");
    a_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");

    c_rx_then_tx: cover property (ctl.hd_state == HD_RX ##[1:800] ctl.hd_state == HD_TX);
    c_clear: cover property (ctl.coef_clear);
    c_mute: cover property (ctl.vol_mute != 2'b00);
endmodule // ecc_ctrl_sva

bind ecc_ctrl ecc_ctrl_sva ecc_ctrl_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .meas, .ctl);

// >>> sim/ecc_peer_model.sv
// Behavioural codecs and canceller front end that feed the measurements.
`timescale 1ns/100ps
module ecc_peer_model
    import ecc_pkg::*;
(
    input wire logic pclk,
    output ecc_meas_t meas
);
    initial meas = '0;

    // A slow source climbs one dB a clock, as a smoothed estimator would; drops are at once.
    task automatic set_pow(input logic [7:0] tx, input logic [7:0] rx, input logic slow);
        do
        begin
            @(posedge pclk);
            meas.tx_pow <= (slow && meas.tx_pow < tx) ? meas.tx_pow + 8'h01 : tx;
            meas.rx_pow <= (slow && meas.rx_pow < rx) ? meas.rx_pow + 8'h01 : rx;
        end while (meas.tx_pow != tx || meas.rx_pow != rx);
    endtask

    task automatic set_peak(input logic [7:0] tx);
        @(posedge pclk);
        meas.tx_peak <= tx;
    endtask

    task automatic set_flags(input logic tone, input logic div, input logic conv);
        @(posedge pclk);
        meas.tone <= tone;
        meas.diverge <= div;
        meas.converged <= conv;
    endtask
endmodule // ecc_peer_model

// >>> sim/ecc_ctrl_bench.sv
// Self-checking bench for the echo canceller control block.
`timescale 1ns/100ps
module ecc_ctrl_bench
    import ecc_pkg::*;
;
    localparam int HOLD = 500;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ecc_meas_t meas;
    ecc_ctl_t ctl;
    logic [31:0] q;
    logic e;
    int fail_count;
    int n_tests;

    // Short ms tick keeps holdover at 500 clocks instead of 5 million.
    ecc_ctrl #(.MS_CYCLES(10), .ATK_CYCLES(5), .DEC_CYCLES(8)) ecc_ctrl_inst (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas, .ctl);
    ecc_peer_model ecc_peer_model_inst (.pclk, .meas);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1, "pready");
        if (pready !== 1'b1)
            complete_run();
    endtask

    task automatic wait_hd(input logic [2:0] s, input int lim);
        #1;
        for (int i = 0; i < lim && ctl.hd_state !== s; i++)
            tick(1);
        chk(32'(ctl.hd_state), 32'(s), "hd state");
        if (ctl.hd_state !== s)
            complete_run();
    endtask

    task automatic t_reset();
        logic [31:0] exp [4] = '{32'h140, 32'h140, 32'h0, 32'h0a0};
        tick(1);
        chk(32'(ctl.coef_clear), 32'h1, "clear at start");
        chk(32'(ctl.hd_active), 32'h1, "half duplex on");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0, q, e);
            chk(q, exp[i], "reset word");
        end
        chk(32'(ctl.rx_sup_db), 32'd24, "rx sup default");
        apb(1'b1, OFF_W2, 32'hffff_ffff, q, e);
        apb(1'b0, OFF_W2, 32'h0, q, e);
        chk(q, 32'h0000_0fff, "upper bits");
        apb(1'b1, OFF_W2, 32'h0, q, e);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        $display("reset and register test done");
    endtask

    task automatic t_thresh();
        apb(1'b1, OFF_W2, 32'hc00, q, e);
        apb(1'b1, OFF_W3, 32'hca0, q, e);
        ecc_peer_model_inst.set_pow(8'd14, 8'd14, 1'b0);
        tick(20);
        chk(32'(ctl.hd_state), 32'(HD_IDLE), "14 dB over is no speech");
        apb(1'b1, OFF_W3, 32'h0a0, q, e);
        wait_hd(HD_TX, 20);
        apb(1'b1, OFF_W2, 32'h0, q, e);
        tick(20);
        chk(32'(ctl.hd_state), 32'(HD_TX), "rx waits");
        chk(32'(ctl.rx_mute), 32'h1, "tx mutes rx");
        ecc_peer_model_inst.set_pow(8'd0, 8'd0, 1'b0);
        wait_hd(HD_IDLE, HOLD + 50);
        $display("threshold test done");
    endtask

    task automatic t_rx_sup();
        ecc_peer_model_inst.set_pow(8'd0, 8'd30, 1'b1);
        wait_hd(HD_RX, 100);
        chk(32'(ctl.tx_mute), 32'h1, "rx mutes tx");
        chk(32'(ctl.rx_sup_db), 32'h0, "rx sup released");
        chk(32'(ctl.tx_sup_db), 32'd6, "tx sup far only");
        ecc_peer_model_inst.set_pow(8'd30, 8'd0, 1'b0);
        tick(HOLD - 50);
        chk(32'(ctl.hd_state), 32'(HD_RX), "holdover");
        chk(32'(ctl.tx_sup_db), 32'h0, "near end lifts");
        chk(32'(ctl.rx_sup_db), 32'd24, "rx sup back");
        wait_hd(HD_TX, 200);
        ecc_peer_model_inst.set_pow(8'd0, 8'd0, 1'b0);
        wait_hd(HD_IDLE, HOLD + 50);
        $display("holdover test done");
    endtask

    task automatic t_flags();
        ecc_peer_model_inst.set_flags(1'b1, 1'b0, 1'b0);
        tick(2);
        chk(32'(ctl.update_en), 32'h0, "tone blocks");
        ecc_peer_model_inst.set_flags(1'b0, 1'b1, 1'b0);
        ecc_peer_model_inst.set_flags(1'b0, 1'b0, 1'b0);
        #1;
        chk(32'(ctl.coef_clear), 32'h1, "divergence clears");
        ecc_peer_model_inst.set_flags(1'b0, 1'b0, 1'b1);
        ecc_peer_model_inst.set_flags(1'b0, 1'b0, 1'b0);
        tick(2);
        chk(32'(ctl.update_en), 32'h1, "update resumes");
        chk(32'(ctl.hd_active), 32'h0, "converged");
        apb(1'b1, OFF_CTRL, 32'h2, q, e);
        #1;
        chk(32'(ctl.coef_clear), 32'h1, "sw clear");
        apb(1'b1, OFF_CTRL, 32'h1, q, e);
        tick(2);
        chk(32'(ctl.hd_active), 32'h1, "re-armed");
        $display("flag test done");
    endtask

    task automatic t_vol();
        logic [7:0] boost [4] = '{8'd0, 8'd9, 8'd18, 8'd36};
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, OFF_W0, 32'h3e0 | 32'(c << 2), q, e);
            tick(2);
            chk(32'(ctl.grade_db[0]), 32'(boost[c]), "early boost");
            chk(32'(ctl.grade_db[3]), 32'h0, "late flat");
        end
        chk(32'(ctl.vol_mute), 32'h2, "rx mute");
        chk(32'(ctl.vol_att_db[1]), 32'd63, "rx att");
        apb(1'b1, OFF_W1, 32'h0, q, e);
        tick(2);
        chk(32'(ctl.post_gain_db[0]), 32'd30, "tx post gain");
        ecc_peer_model_inst.set_peak(8'd70);
        tick(8);
        chk(32'(ctl.agc_att_db[0]), 32'd10, "tx agc attack");
        apb(1'b1, OFF_W1, 32'h140, q, e);
        tick(2);
        chk(32'(ctl.post_gain_db[0]), 32'h0, "unity no agc");
        $display("volume test done");
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_thresh();
        t_rx_sup();
        t_flags();
        t_vol();
        complete_run();
    end
endmodule // ecc_ctrl_bench
